// *** hdl/iopmc_pkg.sv ***
// Constants, field layouts and carrier types of the I/O port and mute block
// Behaviour
// - 56 pins as fourteen four-bit groups
// - Direction bit 0 input, 1 output
// - Select index increments on every direction access
// - Reset clears direction of all fourteen groups
// - Output pins read back the latch
// - Input pins read pin, latch ignored
// - Display-shared pins default to display, port ignored
// - Last segment pin is input only
// - Converter, buzzer, serial groups reset to port
// - Group 1 input change wakes the CPU
// - Trigger enable lets change force mute
// - Mute port written at its own address
// - Polarity bit selects mute pin level
// - Unlock select routes unlock pulses to mute
// - Tone enable puts tone on group3 pin3
package iopmc_pkg;

    // ********************************************************
    // Geometry
    // ********************************************************
    localparam int NUM_GROUPS = 14;
    localparam int GROUP_W = 4;
    localparam int NUM_PINS = NUM_GROUPS * GROUP_W;
    localparam int ADDR_W = 5;
    localparam int LCD_FIRST_GROUP = 6;
    localparam int LAST_SEG_PIN = NUM_PINS - 1;
    localparam int TONE_PIN = 2 * GROUP_W + 3;
    localparam int ADC_GROUP = 1;
    localparam int SERIAL_GROUP = 2;

    // ********************************************************
    // Register offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] ADDR_DATA_LAST = 5'h0d;
    localparam logic [ADDR_W-1:0] ADDR_DIR_SEL = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_DIR_DATA = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_MUTE = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_LCD_LO = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_LCD_HI = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_ALT = 5'h15;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 5'h16;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 5'h17;
    localparam logic [ADDR_W-1:0] ADDR_DISP = 5'h18;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int MUTE_BIT = 0;
    localparam int MUTE_TRIG = 1;
    localparam int MUTE_POL = 2;
    localparam int MUTE_UNLOCK = 3;
    localparam int ALT_ADC = 0;
    localparam int ALT_SERIAL = 1;
    localparam int ALT_TONE = 2;
    localparam int IRQ_CHANGE = 0;
    localparam int IRQ_FORCED = 1;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [NUM_PINS-1:0] RST_DIR = 56'h0;
    localparam logic [NUM_PINS-1:0] RST_LATCH = 56'h0;
    localparam logic [3:0] RST_MUTE = 4'h0;
    localparam logic [7:0] RST_LCD = 8'hff;
    localparam logic [3:0] RST_ALT = 4'h0;
    localparam logic [3:0] RST_SEL = 4'h0;

    // ********************************************************
    // Carriers
    // ********************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [3:0] wdata;
        logic wr;
        logic rd;
    } iopmc_bus_req_t;

    typedef struct packed {
        logic [NUM_PINS-1:0] dir;
        logic [NUM_PINS-1:0] latch;
        logic [3:0] dsel;
        logic [3:0] mute;
        logic [7:0] lcd;
        logic [3:0] alt;
        logic [1:0] stat;
        logic [1:0] mask;
        logic disp_off;
        logic [3:0] g1_prev;
        logic [3:0] rdata;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe;
        logic mute_pin;
        logic wake;
        logic irq;
    } iopmc_state_t;

endpackage

// *** hdl/iopmc_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module iopmc_sync #(
    parameter int WIDTH = 56
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    generate
        if (WIDTH < 1) begin : g_bad
            $error("iopmc_sync width must be positive");
        end
    endgenerate

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] q_next;

    // A bit moves only when stages two and three agree, so one sampled glitch never counts
    always_comb begin
        q_next = (~(s2_reg ^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & q);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q <= q_next;
        end
    end

endmodule

// *** hdl/iopmc_top.sv ***
// I/O port groups with direction select, shared-pin modes and mute output
`timescale 1ns/10ps
module iopmc_top
    import iopmc_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input iopmc_bus_req_t bus_req,
    output logic [3:0] rd_data,
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe,
    input wire logic tone_in,
    input wire logic unlock_pulse,
    output logic mute_pin,
    output logic wakeup,
    output logic irq,
    output logic display_supply_off_bit
);

    // ********************************************************
    // Helpers
    // ********************************************************
    // True when the pin is a plain port pin, not display or alternate use
    function automatic logic is_port(input logic [7:0] lcd, input logic [3:0] alt,
                                     input int idx);
        int g;
        int b;
        logic p;
        g = idx / GROUP_W;
        b = idx % GROUP_W;
        p = 1'b1;
        if (g >= LCD_FIRST_GROUP && lcd[g - LCD_FIRST_GROUP]) begin
            p = 1'b0;
        end
        if (g == ADC_GROUP && alt[ALT_ADC]) begin
            p = 1'b0;
        end
        if (g == SERIAL_GROUP && b < 3 && alt[ALT_SERIAL]) begin
            p = 1'b0;
        end
        if (idx == TONE_PIN && alt[ALT_TONE]) begin
            p = 1'b0;
        end
        return p;
    endfunction

    // ********************************************************
    // Input synchroniser
    // ********************************************************
    logic [NUM_PINS-1:0] pin_sync;

    iopmc_sync #(
        .WIDTH(NUM_PINS)
    ) u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .d(pin_in),
        .q(pin_sync)
    );

    // ********************************************************
    // State update
    // ********************************************************
    iopmc_state_t r;
    iopmc_state_t n;
    logic change;
    logic is_data;
    logic [5:0] base;
    logic [5:0] dbase;

    // fourteen data groups, one address each
    assign is_data = (bus_req.addr <= ADDR_DATA_LAST);
    assign base = {bus_req.addr[3:0], 2'b00};
    assign dbase = {r.dsel, 2'b00};

    always_comb begin
        n = r;
        change = |((pin_sync[3:0] ^ r.g1_prev) & ~r.dir[3:0]);
        n.g1_prev = pin_sync[3:0];
        n.wake = change;
        n.rdata = 4'h0;

        if (bus_req.wr) begin
            if (is_data) begin
                n.latch[base +: 4] = bus_req.wdata;
            end else begin
                unique case (bus_req.addr)
                    ADDR_DIR_SEL: n.dsel = bus_req.wdata;
                    ADDR_DIR_DATA: begin
                        if (r.dsel < 4'(NUM_GROUPS)) begin
                            n.dir[dbase +: 4] = bus_req.wdata;
                        end
                        n.dsel = r.dsel + 4'h1;
                    end
                    ADDR_MUTE: n.mute = bus_req.wdata;
                    ADDR_LCD_LO: n.lcd[3:0] = bus_req.wdata;
                    ADDR_LCD_HI: n.lcd[7:4] = bus_req.wdata;
                    ADDR_ALT: n.alt = bus_req.wdata;
                    ADDR_IRQ_STAT: n.stat = r.stat & ~bus_req.wdata[1:0];
                    ADDR_IRQ_MASK: n.mask = bus_req.wdata[1:0];
                    ADDR_DISP: n.disp_off = bus_req.wdata[0];
                    default: ;
                endcase
            end
        end

        if (bus_req.rd) begin
            if (is_data) begin
                for (int b = 0; b < GROUP_W; b++) begin
                    // output reads latch, input reads pin
                    if (is_port(r.lcd, r.alt, int'(base) + b) && r.dir[int'(base) + b]
                        && (int'(base) + b) != LAST_SEG_PIN) begin
                        n.rdata[b] = r.latch[int'(base) + b];
                    end else begin
                        n.rdata[b] = pin_sync[int'(base) + b];
                    end
                end
            end else begin
                unique case (bus_req.addr)
                    ADDR_DIR_SEL: n.rdata = r.dsel;
                    ADDR_DIR_DATA: begin
                        if (r.dsel < 4'(NUM_GROUPS)) begin
                            n.rdata = r.dir[dbase +: 4];
                        end
                        n.dsel = r.dsel + 4'h1;
                    end
                    ADDR_MUTE: n.rdata = r.mute;
                    ADDR_LCD_LO: n.rdata = r.lcd[3:0];
                    ADDR_LCD_HI: n.rdata = r.lcd[7:4];
                    ADDR_ALT: n.rdata = r.alt;
                    ADDR_IRQ_STAT: n.rdata = {2'b00, r.stat};
                    ADDR_IRQ_MASK: n.rdata = {2'b00, r.mask};
                    ADDR_DISP: n.rdata = {3'b000, r.disp_off};
                    default: n.rdata = 4'h0;
                endcase
            end
        end

        // forced mute; placed after the write so the event wins
        if (change && r.mute[MUTE_TRIG]) begin
            n.mute[MUTE_BIT] = 1'b1;
        end
        // Hardware set wins over a same-cycle clear
        n.stat[IRQ_CHANGE] = n.stat[IRQ_CHANGE] | change;
        n.stat[IRQ_FORCED] = n.stat[IRQ_FORCED] | (change & r.mute[MUTE_TRIG]);
        n.irq = |(n.stat & n.mask);

        if (n.mute[MUTE_UNLOCK]) begin
            n.mute_pin = unlock_pulse;
        end else begin
            n.mute_pin = n.mute[MUTE_POL] ? n.mute[MUTE_BIT] : ~n.mute[MUTE_BIT];
        end

        for (int i = 0; i < NUM_PINS; i++) begin
            // drive only port outputs, never the last segment pin
            n.pin_oe[i] = is_port(n.lcd, n.alt, i) && n.dir[i] && (i != LAST_SEG_PIN);
            n.pin_out[i] = n.pin_oe[i] & n.latch[i];
        end
        if (n.alt[ALT_TONE]) begin
            n.pin_oe[TONE_PIN] = 1'b1;
            n.pin_out[TONE_PIN] = tone_in;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{dir: RST_DIR, latch: RST_LATCH, dsel: RST_SEL, mute: RST_MUTE,
                   lcd: RST_LCD, alt: RST_ALT, stat: 2'h0, mask: 2'h0, disp_off: 1'b0,
                   g1_prev: 4'h0, rdata: 4'h0, pin_out: '0, pin_oe: '0,
                   mute_pin: 1'b1, wake: 1'b0, irq: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign rd_data = r.rdata;
    assign pin_out = r.pin_out;
    assign pin_oe = r.pin_oe;
    assign mute_pin = r.mute_pin;
    assign wakeup = r.wake;
    assign irq = r.irq;
    assign display_supply_off_bit = r.disp_off;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence dir_access_s;
        (bus_req.wr || bus_req.rd) && bus_req.addr == ADDR_DIR_DATA;
    endsequence

    sequence wr_mute_s;
        bus_req.wr && bus_req.addr == ADDR_MUTE;
    endsequence

    chk_dir_index_step: assert property (
        dir_access_s |=> r.dsel == $past(r.dsel) + 4'h1)
        else $error("direction index did not step by one");

    chk_out_latch_read: assert property (
        bus_req.rd && bus_req.addr == 5'h00 && r.dir[0] && !bus_req.wr
        |=> rd_data[0] == $past(r.latch[0]))
        else $error("output pin read did not return latch");

    chk_in_pin_read: assert property (
        bus_req.rd && bus_req.addr == 5'h00 && !r.dir[0]
        |=> rd_data[0] == $past(pin_sync[0]))
        else $error("input pin read did not return pin level");

    chk_lcd_release: assert property (
        r.lcd[7] |-> pin_oe[LAST_SEG_PIN - 1] == 1'b0)
        else $error("display pin driven as port");

    chk_last_seg_in: assert property (
        pin_oe[LAST_SEG_PIN] == 1'b0)
        else $error("last segment pin driven");

    chk_change_wake: assert property (
        change |=> wakeup ##1 (wakeup == $past(change)))
        else $error("group 1 change did not wake");

    chk_mute_force: assert property (
        change && r.mute[MUTE_TRIG] |=> r.mute[MUTE_BIT] && r.stat[IRQ_FORCED])
        else $error("mute not forced on change");

    chk_mute_write: assert property (
        wr_mute_s and (!change) |=> r.mute == $past(bus_req.wdata))
        else $error("mute port write lost");

    chk_mute_polarity: assert property (
        !r.mute[MUTE_UNLOCK]
        |-> mute_pin == (r.mute[MUTE_POL] ? r.mute[MUTE_BIT] : !r.mute[MUTE_BIT]))
        else $error("mute polarity wrong");

    chk_unlock_route: assert property (
        n.mute[MUTE_UNLOCK] |=> mute_pin == $past(unlock_pulse))
        else $error("unlock pulse not on mute pin");

    chk_tone_route: assert property (
        n.alt[ALT_TONE] |=> pin_oe[TONE_PIN] && pin_out[TONE_PIN] == $past(tone_in))
        else $error("tone not on group3 pin3");

endmodule

// *** tb/iopmc_pin_model.sv ***
// External pin world model: resolves each pad from the port drive and the board level
`timescale 1ns/10ps
module iopmc_pin_model
    import iopmc_pkg::*;
(
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe,
    input wire logic [NUM_PINS-1:0] board_level,
    output logic [NUM_PINS-1:0] pin_in
);
    // ****************************************************
    // Pad resolution
    // ****************************************************
    // driven pads follow the port, released pads the board
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : board_level[i];
        end
    end
endmodule

// *** tb/test_iopmc_top.sv ***
// Self-checking bench of the I/O port and mute block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_iopmc_top
    import iopmc_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    iopmc_bus_req_t bus_req = '0;
    logic [3:0] rd_data;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe;
    logic [NUM_PINS-1:0] board = '0;
    logic tone_in = 1'b1;
    logic unlock = 1'b0;
    logic mute_pin, wakeup, irq, disp_off;
    logic woke;
    int num_errors = 0;
    int total_checks = 0;

    always #10 clk = ~clk;

    iopmc_top i_iopmc_top (.clk(clk), .reset_n(reset_n), .bus_req(bus_req),
        .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .tone_in(tone_in), .unlock_pulse(unlock), .mute_pin(mute_pin),
        .wakeup(wakeup), .irq(irq), .display_supply_off_bit(disp_off));

    iopmc_pin_model i_iopmc_pin_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .board_level(board), .pin_in(pin_in));

    // ****************************************************
    // Bus tasks
    // ****************************************************
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rck(input string nm, input logic [4:0] a, input logic [3:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 4'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        `CHK(nm, e, rd_data)
    endtask

    // Outputs land on the same edge as the state, pins need the synchroniser too
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Whole sequence takes well under 1000 cycles
    initial begin
        #(20 * 5000);
        num_errors++;
        close_out();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        settle(6);
        rck("alt", ADDR_ALT, 4'h0);
        rck("lcd_lo", ADDR_LCD_LO, 4'hf);
        rck("lcd_hi", ADDR_LCD_HI, 4'hf);
        rck("mute", ADDR_MUTE, 4'h0);
        rck("unmapped", 5'h1f, 4'h0);
        `CHK("mute_pin", 1'b1, mute_pin)
        `CHK("oe_reset", 56'h0, pin_oe)
        wr(ADDR_DIR_SEL, 4'h0);
        rck("dir_g1", ADDR_DIR_DATA, 4'h0);
        rck("dir_g2", ADDR_DIR_DATA, 4'h0);
        $display("test reset done");

        wr(ADDR_DIR_SEL, 4'h1);
        wr(ADDR_DIR_DATA, 4'h5);
        wr(ADDR_DIR_DATA, 4'h8);
        wr(ADDR_DIR_SEL, 4'h1);
        rck("dir_g2b", ADDR_DIR_DATA, 4'h5);
        rck("dir_g3", ADDR_DIR_DATA, 4'h8);
        settle(2);
        `CHK("oe_g2g3", 8'h85, pin_oe[11:4])
        $display("test direction done");

        @(posedge clk);
        board[7:4] <= 4'h0;
        wr(5'h01, 4'hf);
        settle(8);
        rck("g2_mix", 5'h01, 4'h5);
        `CHK("out_g2", 4'h5, pin_out[7:4])
        board[7:4] <= 4'ha;
        settle(8);
        rck("g2_pin", 5'h01, 4'hf);
        $display("test data done");

        wr(ADDR_IRQ_MASK, 4'h3);
        wr(ADDR_MUTE, 4'h2);
        @(posedge clk);
        board[0] <= 1'b1;
        woke = 1'b0;
        repeat (20) begin
            @(posedge clk);
            #1;
            if (wakeup === 1'b1) begin
                woke = 1'b1;
            end
        end
        `CHK("wakeup", 1'b1, woke)
        rck("mute_forced", ADDR_MUTE, 4'h3);
        `CHK("mute_pin_low", 1'b0, mute_pin)
        rck("stat", ADDR_IRQ_STAT, 4'h3);
        `CHK("irq_set", 1'b1, irq)
        wr(ADDR_IRQ_STAT, 4'h3);
        settle(2);
        `CHK("irq_clr", 1'b0, irq)
        $display("test change done");

        wr(ADDR_MUTE, 4'h5);
        settle(2);
        `CHK("mute_pol", 1'b1, mute_pin)
        wr(ADDR_MUTE, 4'hc);
        unlock <= 1'b1;
        settle(3);
        `CHK("unlock_hi", 1'b1, mute_pin)
        unlock <= 1'b0;
        settle(3);
        `CHK("unlock_lo", 1'b0, mute_pin)
        $display("test mute done");

        wr(ADDR_LCD_LO, 4'h0);
        wr(ADDR_DIR_SEL, 4'h6);
        wr(ADDR_DIR_DATA, 4'hf);
        settle(2);
        `CHK("oe_g7", 4'hf, pin_oe[27:24])
        wr(ADDR_LCD_LO, 4'h1);
        settle(2);
        `CHK("oe_g7_lcd", 4'h0, pin_oe[27:24])
        wr(ADDR_LCD_HI, 4'h0);
        wr(ADDR_DIR_SEL, 4'hd);
        wr(ADDR_DIR_DATA, 4'hf);
        board[55] <= 1'b1;
        settle(8);
        `CHK("oe_g14", 4'h7, pin_oe[55:52])
        rck("g14", ADDR_DATA_LAST, 4'h8);
        $display("test display done");

        wr(ADDR_DISP, 4'h1);
        settle(2);
        `CHK("supply_off", 1'b1, disp_off)
        wr(ADDR_ALT, 4'h4);
        rck("alt_tone", ADDR_ALT, 4'h4);
        `CHK("tone_oe", 1'b1, pin_oe[TONE_PIN])
        tone_in <= 1'b0;
        settle(2);
        `CHK("tone_lo", 1'b0, pin_out[TONE_PIN])
        wr(ADDR_ALT, 4'h3);
        settle(2);
        `CHK("oe_alt", 8'h80, pin_oe[11:4])
        wr(ADDR_DIR_SEL, 4'he);
        wr(ADDR_DIR_DATA, 4'hf);
        wr(ADDR_DIR_SEL, 4'he);
        rck("dir_idx14", ADDR_DIR_DATA, 4'h0);
        $display("test misc done");
        close_out();
    end
endmodule
